// >>> shared/exc_slice_pkg.sv
package exc_slice_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_ROOT_CAUSE  = 8'h04;
  localparam logic [7:0] ADDR_GUEST_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_MATCH_HI    = 8'h0C;
  localparam logic [7:0] ADDR_DEBUG_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h18;
  localparam logic [7:0] ADDR_LAST_TAKEN  = 8'h1C;

  // ==========================================================
  // field positions
  localparam int CTRL_EXL_BIT    = 0;
  localparam int CTRL_GUEST_BIT  = 1;
  localparam int CAUSE_CODE_LSB  = 2;
  localparam int CAUSE_CODE_W    = 5;
  localparam int CAUSE_WP_BIT    = 22;
  localparam int MHI_STORE_BIT   = 0;
  localparam int MHI_LOAD_BIT    = 1;
  localparam int MHI_FETCH_BIT   = 2;
  localparam int DBG_BP_BIT      = 1;
  localparam int IRQ_TAKEN_BIT   = 0;
  localparam int IRQ_DEBUG_BIT   = 1;
  localparam int IRQ_DWATCH_BIT  = 2;
  localparam int IRQ_W           = 3;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_CAUSE    = 32'h0000_0000;
  localparam logic [31:0] RST_MATCH_HI = 32'h0000_0000;
  localparam logic [31:0] RST_DEBUG    = 32'h0000_0000;
  localparam logic [2:0]  RST_IRQ      = 3'h0;

  // ==========================================================
  // exception codes
  localparam logic [4:0] CODE_INT     = 5'h00;
  localparam logic [4:0] CODE_WATCH   = 5'h17;
  localparam logic [4:0] CODE_ADDRERR = 5'h04;
  localparam logic [4:0] CODE_REFILL  = 5'h02;
  localparam logic [4:0] CODE_INVALID = 5'h02;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} access_t;

  typedef enum logic [3:0] {
    KIND_NONE, KIND_ROOT_DWATCH, KIND_GUEST_IRQ, KIND_GUEST_DWATCH, KIND_DEBUG_BREAK,
    KIND_ROOT_FWATCH, KIND_GUEST_FWATCH, KIND_FETCH_ALIGN, KIND_ROOT_REFILL,
    KIND_GUEST_REFILL, KIND_ROOT_INVALID, KIND_GUEST_INVALID
  } kind_t;

  typedef struct packed {
    logic    root_watch;
    access_t root_watch_acc;
    logic    guest_watch;
    access_t guest_watch_acc;
    logic    guest_irq;
    logic    debug_instr_break;
    logic    root_fetch_watch;
    logic    guest_fetch_watch;
    logic    fetch_misaligned;
    logic    root_tlb_miss;
    logic    guest_tlb_miss;
    logic    root_tlb_invalid;
    logic    guest_tlb_invalid;
  } cond_t;

  typedef struct packed {
    logic       valid;
    kind_t      kind;
    logic [4:0] code;
    logic       guest;
    logic       debug;
  } take_t;

  // ==========================================================
  // kind decoding
  function automatic logic [4:0] code_of(input kind_t k);
    unique case (k)
      KIND_GUEST_IRQ:                        code_of = CODE_INT;
      KIND_ROOT_FWATCH, KIND_GUEST_FWATCH:   code_of = CODE_WATCH;
      KIND_FETCH_ALIGN:                      code_of = CODE_ADDRERR;
      KIND_ROOT_REFILL, KIND_GUEST_REFILL:   code_of = CODE_REFILL;
      KIND_ROOT_INVALID, KIND_GUEST_INVALID: code_of = CODE_INVALID;
      default:                               code_of = CODE_WATCH;
    endcase
  endfunction : code_of

  function automatic logic guest_of(input kind_t k, input logic guest_mode);
    unique case (k)
      KIND_GUEST_IRQ, KIND_GUEST_DWATCH, KIND_GUEST_FWATCH,
      KIND_GUEST_REFILL, KIND_GUEST_INVALID: guest_of = 1'b1;
      KIND_FETCH_ALIGN:                      guest_of = guest_mode;
      default:                               guest_of = 1'b0;
    endcase
  endfunction : guest_of

  function automatic logic [2:0] acc_bits(input access_t a);
    acc_bits = 3'h0;
    unique case (a)
      ACC_FETCH: acc_bits[MHI_FETCH_BIT] = 1'b1;
      ACC_LOAD:  acc_bits[MHI_LOAD_BIT]  = 1'b1;
      default:   acc_bits[MHI_STORE_BIT] = 1'b1;
    endcase
  endfunction : acc_bits

endpackage : exc_slice_pkg

// >>> design/exc_select.sv
module exc_select (
  input  wire exc_slice_pkg::cond_t cond,
  input  wire logic                 root_dw_ready,
  input  wire logic                 guest_dw_ready,
  output exc_slice_pkg::kind_t      kind
);
  import exc_slice_pkg::*;

  // ==========================================================
  // fixed priority, highest first
  always_comb begin
    if (root_dw_ready) begin
      kind = KIND_ROOT_DWATCH;
    end else if (cond.guest_irq) begin
      kind = KIND_GUEST_IRQ;
    end else if (guest_dw_ready) begin
      kind = KIND_GUEST_DWATCH;
    end else if (cond.debug_instr_break) begin
      kind = KIND_DEBUG_BREAK;
    end else if (cond.root_fetch_watch) begin
      kind = KIND_ROOT_FWATCH;
    end else if (cond.guest_fetch_watch) begin
      kind = KIND_GUEST_FWATCH;
    end else if (cond.fetch_misaligned) begin
      kind = KIND_FETCH_ALIGN;
    end else if (cond.root_tlb_miss) begin
      kind = KIND_ROOT_REFILL;
    end else if (cond.guest_tlb_miss) begin
      kind = KIND_GUEST_REFILL;
    end else if (cond.root_tlb_invalid) begin
      kind = KIND_ROOT_INVALID;
    end else if (cond.guest_tlb_invalid) begin
      kind = KIND_GUEST_INVALID;
    end else begin
      kind = KIND_NONE;
    end
  end

endmodule : exc_select

// >>> design/exception_priority_slice.sv
// The address map and register access over APB are this design's own decisions.
module exception_priority_slice (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire exc_slice_pkg::cond_t cond,
  output exc_slice_pkg::take_t      take,
  output logic                      irq
);
  import exc_slice_pkg::*;

  // ==========================================================
  // state
  logic [31:0] ctrl;
  logic [31:0] root_cause;
  logic [31:0] guest_cause;
  logic [31:0] address_match_hi_reg;
  logic [31:0] debug_state;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic        root_pend;
  access_t     root_pend_acc;
  logic        guest_pend;
  access_t     guest_pend_acc;
  take_t       last_taken;

  logic [31:0] next_ctrl;
  logic [31:0] next_root_cause;
  logic [31:0] next_guest_cause;
  logic [31:0] next_match_hi;
  logic [31:0] next_debug_state;
  logic [2:0]  next_irq_status;
  logic [2:0]  next_irq_mask;
  logic        next_root_pend;
  access_t     next_root_pend_acc;
  logic        next_guest_pend;
  access_t     next_guest_pend_acc;
  take_t       next_take;
  take_t       next_last_taken;
  logic        next_irq;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic        exception_level_flag;
  logic        guest_mode;
  logic        root_dw_ready;
  logic        guest_dw_ready;
  kind_t       sel;
  logic        wr_done;
  logic        rd_done;
  logic [2:0]  ev;

  assign exception_level_flag = ctrl[CTRL_EXL_BIT];
  assign guest_mode           = ctrl[CTRL_GUEST_BIT];
  assign wr_done              = psel & penable & pready & pwrite;
  assign rd_done              = psel & penable & pready & ~pwrite;

  assign root_dw_ready  = root_pend & ~exception_level_flag;
  assign guest_dw_ready = guest_pend & ~exception_level_flag;

  exc_select u_select (
    .cond           (cond),
    .root_dw_ready  (root_dw_ready),
    .guest_dw_ready (guest_dw_ready),
    .kind           (sel)
  );

  // ==========================================================
  // exception taking and registers
  always_comb begin
    next_ctrl           = ctrl;
    next_root_cause     = root_cause;
    next_guest_cause    = guest_cause;
    next_match_hi       = address_match_hi_reg;
    next_debug_state    = debug_state;
    next_irq_mask       = irq_mask;
    next_root_pend      = root_pend;
    next_root_pend_acc  = root_pend_acc;
    next_guest_pend     = guest_pend;
    next_guest_pend_acc = guest_pend_acc;
    next_last_taken     = last_taken;
    ev                  = 3'h0;
    // software writes first, hardware updates below win
    if (wr_done) begin
      unique case (paddr)
        ADDR_CTRL:        next_ctrl = {30'h0000_0000, pwdata[1:0]};
        ADDR_ROOT_CAUSE:  next_root_cause = pwdata;
        ADDR_GUEST_CAUSE: next_guest_cause = pwdata;
        ADDR_MATCH_HI:    next_match_hi = {29'h0000_0000, pwdata[2:0]};
        ADDR_DEBUG_STATE: next_debug_state = {30'h0000_0000, pwdata[1:0]};
        ADDR_IRQ_MASK:    next_irq_mask = pwdata[2:0];
        default:          next_ctrl = ctrl;
      endcase
    end
    // pending watch released when taken
    if (sel == KIND_ROOT_DWATCH) begin
      next_root_pend = 1'b0;
    end
    if (sel == KIND_GUEST_DWATCH) begin
      next_guest_pend = 1'b0;
    end
    if (cond.root_watch) begin
      next_root_pend     = 1'b1;
      next_root_pend_acc = cond.root_watch_acc;
    end
    if (cond.guest_watch) begin
      next_guest_pend     = 1'b1;
      next_guest_pend_acc = cond.guest_watch_acc;
    end
    next_take.valid = sel != KIND_NONE;
    next_take.kind  = sel;
    next_take.code  = code_of(sel);
    next_take.guest = guest_of(sel, guest_mode);
    next_take.debug = sel == KIND_DEBUG_BREAK;
    if (sel == KIND_DEBUG_BREAK) begin
      next_debug_state[DBG_BP_BIT] = 1'b1;
      ev[IRQ_DEBUG_BIT]            = 1'b1;
    end else if (sel == KIND_ROOT_DWATCH) begin
      next_root_cause[CAUSE_WP_BIT] = 1'b1;
      next_match_hi[2:0]            = address_match_hi_reg[2:0] | acc_bits(root_pend_acc);
      next_ctrl[CTRL_EXL_BIT]       = 1'b1;
      ev[IRQ_DWATCH_BIT]            = 1'b1;
    end else if (sel == KIND_GUEST_DWATCH) begin
      next_guest_cause[CAUSE_WP_BIT] = 1'b1;
      next_match_hi[2:0]             = address_match_hi_reg[2:0] | acc_bits(guest_pend_acc);
      next_ctrl[CTRL_EXL_BIT]        = 1'b1;
      ev[IRQ_DWATCH_BIT]             = 1'b1;
    end else if (sel != KIND_NONE) begin
      if (next_take.guest) begin
        next_guest_cause[CAUSE_CODE_LSB +: CAUSE_CODE_W] = next_take.code;
      end else begin
        next_root_cause[CAUSE_CODE_LSB +: CAUSE_CODE_W] = next_take.code;
      end
      next_ctrl[CTRL_EXL_BIT] = 1'b1;
    end
    if (next_take.valid) begin
      next_last_taken   = next_take;
      ev[IRQ_TAKEN_BIT] = 1'b1;
    end
    // read clears status, new events win
    next_irq_status = ((rd_done && paddr == ADDR_IRQ_STATUS) ? 3'h0 : irq_status) | ev;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  // ==========================================================
  // apb slave, one wait state
  always_comb begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (next_pready) begin
      unique case (paddr)
        ADDR_CTRL:        next_prdata = ctrl;
        ADDR_ROOT_CAUSE:  next_prdata = root_cause;
        ADDR_GUEST_CAUSE: next_prdata = guest_cause;
        ADDR_MATCH_HI:    next_prdata = address_match_hi_reg;
        ADDR_DEBUG_STATE: next_prdata = debug_state;
        ADDR_IRQ_STATUS:  next_prdata = {29'h0000_0000, irq_status | ev};
        ADDR_IRQ_MASK:    next_prdata = {29'h0000_0000, irq_mask};
        ADDR_LAST_TAKEN:  next_prdata = {16'h0000, 4'h0, last_taken.kind, 1'b0,
                                         last_taken.code, last_taken.guest, last_taken.debug};
        default:          next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                 <= RST_CTRL;
      root_cause           <= RST_CAUSE;
      guest_cause          <= RST_CAUSE;
      address_match_hi_reg <= RST_MATCH_HI;
      debug_state          <= RST_DEBUG;
      irq_status           <= RST_IRQ;
      irq_mask             <= RST_IRQ;
      root_pend            <= 1'b0;
      root_pend_acc        <= ACC_FETCH;
      guest_pend           <= 1'b0;
      guest_pend_acc       <= ACC_FETCH;
      take                 <= '0;
      last_taken           <= '0;
      irq                  <= 1'b0;
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      ctrl                 <= next_ctrl;
      root_cause           <= next_root_cause;
      guest_cause          <= next_guest_cause;
      address_match_hi_reg <= next_match_hi;
      debug_state          <= next_debug_state;
      irq_status           <= next_irq_status;
      irq_mask             <= next_irq_mask;
      root_pend            <= next_root_pend;
      root_pend_acc        <= next_root_pend_acc;
      guest_pend           <= next_guest_pend;
      guest_pend_acc       <= next_guest_pend_acc;
      take                 <= next_take;
      last_taken           <= next_last_taken;
      irq                  <= next_irq;
      prdata               <= next_prdata;
      pready               <= next_pready;
      pslverr              <= next_pslverr;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // no root watch while level set
  root_defer_a: assert property (exception_level_flag |=> take.kind != KIND_ROOT_DWATCH)
    else $error("root deferred watch taken while exception level set");
  root_wp_a: assert property (sel == KIND_ROOT_DWATCH |=> root_cause[CAUSE_WP_BIT] && ctrl[CTRL_EXL_BIT])
    else $error("root watch pending bit not set");
  // no guest watch while level set
  guest_defer_a: assert property (exception_level_flag |=> take.kind != KIND_GUEST_DWATCH)
    else $error("guest deferred watch taken while exception level set");
  guest_wp_a: assert property (sel == KIND_GUEST_DWATCH |=> guest_cause[CAUSE_WP_BIT])
    else $error("guest watch pending bit not set");
  guest_irq_a: assert property (cond.guest_irq && !root_dw_ready |=> take.code == 5'h00 && take.guest)
    else $error("guest interrupt code wrong");
  dbg_flag_a: assert property (take.debug |-> debug_state[DBG_BP_BIT])
    else $error("breakpoint flag not set");
  dbg_prio_a: assert property (cond.debug_instr_break && !cond.guest_irq && !root_dw_ready && !guest_dw_ready
                               |=> take.kind == KIND_DEBUG_BREAK)
    else $error("instruction break lost to lower exception");
  fwatch_code_a: assert property (take.kind == KIND_ROOT_FWATCH |-> take.code == 5'h17 && !take.guest)
    else $error("root fetch watch code wrong");
  align_code_a: assert property (sel == KIND_FETCH_ALIGN |=> take.code == 5'h04
                                 && take.guest == $past(guest_mode))
    else $error("fetch alignment code or mode wrong");
  cause_code_a: assert property (take.valid && !take.debug && take.kind != KIND_ROOT_DWATCH
                                 && take.kind != KIND_GUEST_DWATCH && !take.guest
                                 |-> root_cause[CAUSE_CODE_LSB +: CAUSE_CODE_W] == take.code)
    else $error("root cause code does not match taken exception");
  guest_code_a: assert property (take.valid && !take.debug && take.kind != KIND_ROOT_DWATCH
                                 && take.kind != KIND_GUEST_DWATCH && take.guest
                                 |-> guest_cause[CAUSE_CODE_LSB +: CAUSE_CODE_W] == take.code)
    else $error("guest cause code does not match taken exception");
  root_first_a: assert property (root_dw_ready |=> take.kind == KIND_ROOT_DWATCH)
    else $error("root deferred watch lost to lower exception");
  fwatch_prio_a: assert property (cond.root_fetch_watch && !cond.debug_instr_break && !cond.guest_irq
                                  && !root_dw_ready && !guest_dw_ready
                                  |=> take.kind == KIND_ROOT_FWATCH)
    else $error("root fetch watch lost to lower exception");
  gfwatch_code_a: assert property (take.kind == KIND_GUEST_FWATCH |-> take.code == CODE_WATCH && take.guest)
    else $error("guest fetch watch code wrong");
  root_refill_a: assert property (take.kind == KIND_ROOT_REFILL |-> take.code == CODE_REFILL && !take.guest)
    else $error("root refill code or mode wrong");
  guest_refill_a: assert property (take.kind == KIND_GUEST_REFILL |-> take.code == CODE_REFILL && take.guest)
    else $error("guest refill code or mode wrong");
  root_inval_a: assert property (take.kind == KIND_ROOT_INVALID |-> take.code == CODE_INVALID && !take.guest)
    else $error("root invalid code or mode wrong");
  guest_inval_a: assert property (take.kind == KIND_GUEST_INVALID |-> take.code == CODE_INVALID && take.guest)
    else $error("guest invalid code or mode wrong");

endmodule : exception_priority_slice

// >>> tb/pipe_stage_model.sv
module pipe_stage_model (
  input  wire exc_slice_pkg::cond_t req,
  input  wire logic                 req_valid,
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  output exc_slice_pkg::cond_t      cond
);
  timeunit 1ns;
  timeprecision 1ps;
  import exc_slice_pkg::*;

  cond_t next_cond;

  // ==========================================================
  // fetch and load/store report: one cycle per request, idle otherwise
  always_comb begin
    next_cond = req_valid ? req : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond <= '0;
    end else begin
      cond <= next_cond;
    end
  end
endmodule : pipe_stage_model

// >>> tb/exception_priority_slice_tb.sv
module exception_priority_slice_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_slice_pkg::*;

  typedef struct packed {
    kind_t      kind;
    logic [4:0] code;
    logic       guest;
    logic       debug;
    logic       chk_code;
  } note_t;

  logic        pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, req_valid, gm, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0]  hits;
  cond_t       req, cond, c;
  take_t       take;
  access_t     acc;
  note_t       mon_note;
  note_t       notes[$];
  int          err_count, total_checks, cycles;
  kind_t       kinds[9] = '{KIND_GUEST_IRQ, KIND_DEBUG_BREAK, KIND_ROOT_FWATCH, KIND_GUEST_FWATCH,
                            KIND_FETCH_ALIGN, KIND_ROOT_REFILL, KIND_GUEST_REFILL, KIND_ROOT_INVALID,
                            KIND_GUEST_INVALID};
  logic [4:0]  codes[9] = '{CODE_INT, CODE_INT, CODE_WATCH, CODE_WATCH, CODE_ADDRERR, CODE_REFILL,
                            CODE_REFILL, CODE_INVALID, CODE_INVALID};
  logic [8:0]  gmask    = 9'h149;

  exception_priority_slice exception_priority_slice_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond), .take(take),
    .irq(irq));
  pipe_stage_model pipe_stage_model_i (
    .req(req), .req_valid(req_valid), .pclk(pclk), .presetn(presetn), .cond(cond));

  // ==========================================================
  // clock, timeout, verdict
  always #2.5 pclk = ~pclk;

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ==========================================================
  // apb master and condition driver
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  task automatic fire(input cond_t cv);
    req <= cv;
    req_valid <= 1'b1;
    @(posedge pclk);
    req_valid <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : fire

  function automatic cond_t build(input int i, input logic [8:0] extra);
    cond_t b;
    b = '0;
    for (int j = i; j < 9; j++) begin
      if (j == i || extra[j]) begin
        case (j)
          0: b.guest_irq = 1'b1;
          1: b.debug_instr_break = 1'b1;
          2: b.root_fetch_watch = 1'b1;
          3: b.guest_fetch_watch = 1'b1;
          4: b.fetch_misaligned = 1'b1;
          5: b.root_tlb_miss = 1'b1;
          6: b.guest_tlb_miss = 1'b1;
          7: b.root_tlb_invalid = 1'b1;
          default: b.guest_tlb_invalid = 1'b1;
        endcase
      end
    end
    return b;
  endfunction : build

  function automatic note_t mk(input kind_t k, input logic [4:0] cd, input logic g, input logic dg,
                               input logic cc);
    mk = '{kind: k, code: cd, guest: g, debug: dg, chk_code: cc};
  endfunction : mk

  // ==========================================================
  // monitor: every take is compared with the oldest note
  always @(posedge pclk) begin
    if (presetn === 1'b1 && take.valid === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'(take.valid), 32'h0);
      end else begin
        mon_note = notes.pop_front();
        check(32'(take.kind), 32'(mon_note.kind));
        check(32'({take.guest, take.debug}), 32'({mon_note.guest, mon_note.debug}));
        if (mon_note.chk_code) check(32'(take.code), 32'(mon_note.code));
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    req = '0; req_valid = 0; gm = 0; hits = 3'h0;
    seed = $urandom(40878);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, RST_CTRL);
    apb(1'b0, ADDR_MATCH_HI, 32'h0);
    check(rd, RST_MATCH_HI);
    // priority sweep, random lower-priority extras, both modes
    for (int p = 0; p < 2; p++) begin
      gm = p[0];
      apb(1'b1, ADDR_CTRL, 32'(gm) << CTRL_GUEST_BIT);
      for (int i = 0; i < 9; i++) begin
        notes.push_back(mk(kinds[i], codes[i], (i == 4) ? gm : gmask[i], i == 1, i != 1));
        fire(build(i, 9'($urandom)));
      end
    end
    apb(1'b0, ADDR_ROOT_CAUSE, 32'h0);
    check(32'(rd[6:2]), 32'(CODE_INVALID));
    apb(1'b0, ADDR_GUEST_CAUSE, 32'h0);
    check(32'(rd[6:2]), 32'(CODE_INVALID));
    apb(1'b0, ADDR_LAST_TAKEN, 32'h0);
    check(rd, 32'({KIND_GUEST_INVALID, 1'b0, CODE_INVALID, 1'b1, 1'b0}));
    apb(1'b0, ADDR_DEBUG_STATE, 32'h0);
    check(32'(rd[DBG_BP_BIT]), 32'h1);
    // deferred watches: held while exception level set
    for (int x = 0; x < 2; x++) begin
      acc = access_t'($urandom_range(2, 0));
      c = '0;
      if (x == 0) begin
        c.root_watch = 1'b1;
        c.root_watch_acc = acc;
      end else begin
        c.guest_watch = 1'b1;
        c.guest_watch_acc = acc;
      end
      fire(c);
      notes.push_back(mk(x ? KIND_GUEST_DWATCH : KIND_ROOT_DWATCH, 5'h0, x[0], 1'b0, 1'b0));
      apb(1'b1, ADDR_CTRL, 32'(gm) << CTRL_GUEST_BIT);
      repeat (4) @(posedge pclk);
      hits = hits | ((acc == ACC_FETCH) ? 3'h4 : (acc == ACC_LOAD) ? 3'h2 : 3'h1);
      apb(1'b0, x ? ADDR_GUEST_CAUSE : ADDR_ROOT_CAUSE, 32'h0);
      check(32'(rd[CAUSE_WP_BIT]), 32'h1);
      apb(1'b0, ADDR_MATCH_HI, 32'h0);
      check(rd, 32'(hits));
    end
    // interrupt: mask, read-clear, masked event, unmasked event
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check(rd, 32'h7);
    repeat (3) @(posedge pclk);
    check(32'(irq), 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h2);
    notes.push_back(mk(KIND_ROOT_REFILL, CODE_REFILL, 1'b0, 1'b0, 1'b1));
    fire(build(5, 9'h0));
    check(32'(irq), 32'h0);
    notes.push_back(mk(KIND_DEBUG_BREAK, CODE_INT, 1'b0, 1'b1, 1'b0));
    fire(build(1, 9'h0));
    check(32'(irq), 32'h1);
    // unmapped addresses
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h24, 32'h1234_5678);
    check(32'(er), 32'h1);
    repeat (5) @(posedge pclk);
    check(32'(notes.size()), 32'h0);
    end_sim();
  end
endmodule : exception_priority_slice_tb
